// ---- core/dbs_pkg.sv ----
package dbs_pkg;

	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam logic [7:0] PIN_MODE_ADDR   = 8'h3C;
	localparam logic [7:0] STROBE_LEN_ADDR = 8'h60;
	localparam logic [7:0] CONFIG_ADDR     = 8'h64;
	localparam logic [7:0] STATUS_ADDR     = 8'h68;
	localparam logic [7:0] REQUEST_ADDR    = 8'h6C;

	// ------------------------------------------------------------
	// Field positions of the pin polarity and mode register
	// ------------------------------------------------------------
	localparam int SWAP_LSB   = 6;
	localparam int SWAP_MSB   = 7;
	localparam int TRANSFER_END_POLARITY_B  = 5;
	localparam int MASTER_B   = 4;
	localparam int ACKNOWLEDGE_POLARITY_B  = 3;
	localparam int REQ_POL_B  = 2;
	localparam int WR_POL_B   = 1;
	localparam int RD_POL_B   = 0;

	// ------------------------------------------------------------
	// Field positions of the configuration register
	// ------------------------------------------------------------
	localparam int WIDTH_B    = 0;
	localparam int UTIM_LSB   = 1;
	localparam int UTIM_MSB   = 2;

	// ------------------------------------------------------------
	// Field positions of the request register
	// ------------------------------------------------------------
	localparam int REQ_B      = 0;
	localparam int DIR_B      = 1;
	localparam int UDMA_B     = 2;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [7:0] PIN_MODE_RST   = 8'h04;
	localparam logic [7:0] STROBE_LEN_RST = 8'h1F;
	localparam logic [7:0] CONFIG_RST     = 8'h01;
	localparam int         STROBE_W       = 5;

	// ------------------------------------------------------------
	// Codes
	// ------------------------------------------------------------
	localparam logic [1:0] SWAP_NORMAL  = 2'h0;
	localparam logic [1:0] SWAP_SWAPPED = 2'h1;
	localparam logic [1:0] UTIM_MODE0   = 2'h0;
	localparam logic [1:0] UTIM_MODE1   = 2'h1;
	localparam logic [1:0] UTIM_MODE2   = 2'h2;
	localparam logic [1:0] UTIM_PROG    = 2'h3;

	// ------------------------------------------------------------
	// Timing: one strobe cycle of ultra timing mode 2, in ns
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS   = 25;
	localparam int UCYCLE_NS       = 50;
	localparam int UCYCLE_CLKS     =
		(UCYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int STD_HOLD_MODE0  = 8;
	localparam int STD_HOLD_MODE1  = 5;
	localparam int STD_HOLD_MODE2  = 3;

	// ------------------------------------------------------------
	// Strobe sequencer states
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		SEQ_IDLE   = 3'b001,
		SEQ_STROBE = 3'b010,
		SEQ_DONE   = 3'b100
	} dbs_seq_t;

endpackage

// ---- core/dbs_pol.sv ----
`timescale 1ns/1ps

// Applies a programmable polarity to one handshake signal.
module dbs_pol (
	input  wire logic active_high,
	input  wire logic asserted,
	output wire logic pin_level
);

	// ------------------------------------------------------------
	// Polarity
	// ------------------------------------------------------------
	// A low polarity bit inverts the logical level on the pin.
	assign pin_level = active_high ? asserted : ~asserted;

endmodule

// ---- core/dbs_swap.sv ----
`timescale 1ns/1ps

// Exchanges the halves of a data word, nibbles or bytes by bus width.
module dbs_swap (
	input  wire logic [15:0] din,
	input  wire logic        swap_en,
	input  wire logic        wide,
	output wire logic [15:0] dout
);

	// ------------------------------------------------------------
	// Half exchange
	// ------------------------------------------------------------
	wire logic [15:0] byte_x;
	wire logic [15:0] nib_x;

	// Byte exchange on the wide bus, nibble exchange on the narrow one.
	assign byte_x = {din[7:0], din[15:8]};
	assign nib_x  = {8'h00, din[3:0], din[7:4]};
	assign dout   = !swap_en ? (wide ? din : {8'h00, din[7:0]}) :
		(wide ? byte_x : nib_x);

endmodule

// ---- core/dbs_top.sv ----
//
// Contract
// R1 - Swap code 00: upper nibble on bits 7..4, upper byte on 15..8.
// R2 - Swap code 01: halves exchanged, nibble for 8-bit, byte for 16-bit; here no swap in ultra transfers.
// R3 - Swap applies only to RAM-to-bus data in slave and master modes; here it also swaps bus-to-RAM data.
// R4 - Software avoids reserved swap codes; treated here as normal.
// R5 - End-of-transfer input polarity by its bit; slave mode only.
// R6 - Master-select bit 0 gives slave mode, 1 master; resets 0.
// R7 - Acknowledge polarity by its bit: 0 active low; resets 0.
// R8 - Request polarity by its bit; resets 1, active high.
// R9 - Write strobe polarity by its bit: 0 active low; resets 0.
// R10 - Read strobe polarity by its bit: 0 active low; resets 0.
// R11 - Programmable mode holds each strobe N+1 cycles; N resets 1F. Here N+1 in ultra transfers only, mode 2 length otherwise.
// R12 - Strobe count used only when timing field is 03.
// R13 - Programmable cycles last as long as standard mode 2 cycles.
// R14 - Timing codes 00..02 select standard modes 0..2; 03 programmable.
// R15 - Width bit 0 selects 8-bit bus, 1 selects 16-bit bus.
//
// Local design decision: register access over APB.
`timescale 1ns/1ps

module dbs_top (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output wire logic [31:0] prdata,
	output wire logic        pready,
	output wire logic        pslverr,
	input  wire logic [15:0] ram_rdata,
	output logic      [15:0] dma_data_out,
	output wire logic        dma_data_oe,
	input  wire logic [15:0] dma_data_in,
	output logic      [15:0] ram_wdata,
	output wire logic        request_pin,
	input  wire logic        acknowledge_pin,
	input  wire logic        transfer_end_input,
	output wire logic        write_strobe_pin,
	output wire logic        read_strobe_pin,
	output wire logic        master_dma,
	output wire logic        generic_slave_dma,
	output wire logic        bus_wide
);

	// ------------------------------------------------------------
	// Register state
	// ------------------------------------------------------------
	// Software registers, pin synchronisers and sequencer state.
	logic [7:0]             pin_mode_r;
	logic [7:0]             strobe_len_r;
	logic [7:0]             config_r;
	logic                   eot_seen_r;
	logic                   ack_s1_r;
	logic                   ack_s2_r;
	logic                   ack_s3_r;
	logic                   eot_s1_r;
	logic                   eot_s2_r;
	logic                   eot_s3_r;
	logic                   ack_lvl_r;
	logic                   eot_lvl_r;
	logic                   dir_r;
	logic                   udma_r;
	logic                   go_r;
	dbs_pkg::dbs_seq_t      state_r;
	dbs_pkg::dbs_seq_t      state_nxt;
	logic [7:0]             hold_cnt_r;
	logic [7:0]             hold_cnt_nxt;
	logic [7:0]             tick_cnt_r;

	// ------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------
	// Select lines, write enable and request strobes.
	wire logic        wr_en;
	wire logic        sel_pin;
	wire logic        sel_len;
	wire logic        sel_cfg;
	wire logic        sel_sts;
	wire logic        sel_req;
	wire logic        mapped;
	wire logic [31:0] sts_word;
	wire logic        req_start;
	wire logic        eot_clear;

	// Address decode; unmapped addresses answer with an error.
	assign sel_pin   = paddr == dbs_pkg::PIN_MODE_ADDR;
	assign sel_len   = paddr == dbs_pkg::STROBE_LEN_ADDR;
	assign sel_cfg   = paddr == dbs_pkg::CONFIG_ADDR;
	assign sel_sts   = paddr == dbs_pkg::STATUS_ADDR;
	assign sel_req   = paddr == dbs_pkg::REQUEST_ADDR;
	assign mapped    = sel_pin | sel_len | sel_cfg | sel_sts | sel_req;
	assign wr_en     = psel & penable & pwrite & mapped;
	assign pready    = 1'b1;
	assign pslverr   = psel & penable & ~mapped;
	assign req_start = wr_en & sel_req & pwdata[dbs_pkg::REQ_B];
	assign eot_clear = wr_en & sel_sts;

	// ------------------------------------------------------------
	// Read back
	// ------------------------------------------------------------
	// Status word: sequencer busy, synchronised pins, end seen.
	assign sts_word = {28'h0000000, eot_seen_r, eot_lvl_r, ack_lvl_r,
		state_r != dbs_pkg::SEQ_IDLE};

	// Read data multiplexer; reserved bits read as zero, except strobe length bits 7..5, which read back as written.
	assign prdata = !(psel & ~pwrite) ? 32'h00000000 :
		sel_pin ? {24'h000000, pin_mode_r} :
		sel_len ? {24'h000000, strobe_len_r} :
		sel_cfg ? {24'h000000, config_r} :
		sel_sts ? sts_word :
		sel_req ? {29'h0, udma_r, dir_r, go_r} : 32'h00000000;

	// Register writes take effect at the access edge.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_mode_r   <= dbs_pkg::PIN_MODE_RST; // R6 R7 R8 R9 R10
			strobe_len_r <= dbs_pkg::STROBE_LEN_RST; // R11
			config_r     <= dbs_pkg::CONFIG_RST;
		end else if (wr_en) begin
			if (sel_pin)
				pin_mode_r <= pwdata[7:0];
			if (sel_len)
				strobe_len_r <= pwdata[7:0];
			if (sel_cfg)
				config_r <= {5'h00, pwdata[2:0]};
		end
	end

	// ------------------------------------------------------------
	// Mode decode
	// ------------------------------------------------------------
	wire logic [1:0] swap_sel;
	wire logic [1:0] utim_sel;
	wire logic       swap_on;

	// Operating mode, bus width and the two code fields.
	assign master_dma        = pin_mode_r[dbs_pkg::MASTER_B]; // R6
	assign generic_slave_dma = ~master_dma; // R6
	assign bus_wide          = config_r[dbs_pkg::WIDTH_B]; // R15
	assign swap_sel = pin_mode_r[dbs_pkg::SWAP_MSB:dbs_pkg::SWAP_LSB];
	assign utim_sel = config_r[dbs_pkg::UTIM_MSB:dbs_pkg::UTIM_LSB];
	// Reserved codes fall back to the normal layout.
	assign swap_on  = (swap_sel == dbs_pkg::SWAP_SWAPPED) & ~udma_r; // R2 R3 R4

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	// Idle levels under the reset polarities; reset shows no false event.
	localparam logic ACK_IDLE = ~dbs_pkg::PIN_MODE_RST[dbs_pkg::ACKNOWLEDGE_POLARITY_B];
	localparam logic EOT_IDLE = ~dbs_pkg::PIN_MODE_RST[dbs_pkg::TRANSFER_END_POLARITY_B];

	// Three stages; a change counts once stages two and three agree.
	// A polarity change reads as an event until the stages settle, so
	// software changes polarities only while no transfer is pending.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ack_s1_r  <= ACK_IDLE;
			ack_s2_r  <= ACK_IDLE;
			ack_s3_r  <= ACK_IDLE;
			eot_s1_r  <= EOT_IDLE;
			eot_s2_r  <= EOT_IDLE;
			eot_s3_r  <= EOT_IDLE;
			ack_lvl_r <= ACK_IDLE;
			eot_lvl_r <= EOT_IDLE;
		end else begin
			ack_s1_r <= acknowledge_pin;
			ack_s2_r <= ack_s1_r;
			ack_s3_r <= ack_s2_r;
			eot_s1_r <= transfer_end_input;
			eot_s2_r <= eot_s1_r;
			eot_s3_r <= eot_s2_r;
			if (ack_s2_r == ack_s3_r)
				ack_lvl_r <= ack_s3_r;
			if (eot_s2_r == eot_s3_r)
				eot_lvl_r <= eot_s3_r;
		end
	end

	// Logical assertion levels after polarity.
	wire logic ack_act;
	wire logic eot_act;

	assign ack_act = ack_lvl_r ~^ pin_mode_r[dbs_pkg::ACKNOWLEDGE_POLARITY_B]; // R7
	assign eot_act = (eot_lvl_r ~^ pin_mode_r[dbs_pkg::TRANSFER_END_POLARITY_B]) &
		generic_slave_dma; // R5

	// Sticky end-of-transfer flag; a new event wins over the clear.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			eot_seen_r <= 1'b0;
		else if (eot_act)
			eot_seen_r <= 1'b1; // R5
		else if (eot_clear)
			eot_seen_r <= 1'b0;
	end

	// ------------------------------------------------------------
	// Strobe length selection
	// ------------------------------------------------------------
	// The count field is five bits, so a hold never exceeds 32 units.
	wire logic [7:0] hold_len;

	// Standard codes use fixed lengths; code 03 uses N+1 in ultra transfers, the mode 2 length otherwise.
	assign hold_len =
		utim_sel == dbs_pkg::UTIM_MODE0 ? 8'(dbs_pkg::STD_HOLD_MODE0) :
		utim_sel == dbs_pkg::UTIM_MODE1 ? 8'(dbs_pkg::STD_HOLD_MODE1) :
		utim_sel == dbs_pkg::UTIM_MODE2 ? 8'(dbs_pkg::STD_HOLD_MODE2) :
		(udma_r ? 8'(strobe_len_r[dbs_pkg::STROBE_W-1:0]) + 8'h01 :
		8'(dbs_pkg::STD_HOLD_MODE2)); // R11 R12 R14

	// ------------------------------------------------------------
	// Strobe sequencer
	// ------------------------------------------------------------
	// Divides the clock down to timing cycles of the strobe.
	wire logic tick;

	// One timing cycle lasts as long as a mode 2 cycle.
	assign tick = tick_cnt_r == 8'(dbs_pkg::UCYCLE_CLKS - 1); // R13

	// Next state and hold count.
	always_comb begin
		state_nxt    = state_r;
		hold_cnt_nxt = hold_cnt_r;
		case (state_r)
			dbs_pkg::SEQ_IDLE: begin
				if (go_r & (master_dma | ack_act)) begin
					state_nxt    = dbs_pkg::SEQ_STROBE;
					hold_cnt_nxt = hold_len;
				end
			end
			dbs_pkg::SEQ_STROBE: begin
				if (tick) begin
					hold_cnt_nxt = hold_cnt_r - 8'h01;
					if (hold_cnt_r == 8'h01)
						state_nxt = dbs_pkg::SEQ_DONE; // R11
				end
			end
			dbs_pkg::SEQ_DONE: begin
				state_nxt = dbs_pkg::SEQ_IDLE;
			end
			default: begin
				state_nxt = dbs_pkg::SEQ_IDLE;
			end
		endcase
	end

	// Sequencer registers; the tick counter only runs while strobing,
	// so every strobe starts on a whole timing cycle.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r    <= dbs_pkg::SEQ_IDLE;
			hold_cnt_r <= 8'h00;
			tick_cnt_r <= 8'h00;
		end else begin
			state_r    <= state_nxt;
			hold_cnt_r <= hold_cnt_nxt;
			if (state_r != dbs_pkg::SEQ_STROBE || tick)
				tick_cnt_r <= 8'h00;
			else
				tick_cnt_r <= tick_cnt_r + 8'h01;
		end
	end

	// Transfer request from software; cleared when the strobe ends.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			go_r   <= 1'b0;
			dir_r  <= 1'b0;
			udma_r <= 1'b0;
		end else if (req_start && !go_r) begin
			go_r   <= 1'b1;
			dir_r  <= pwdata[dbs_pkg::DIR_B];
			udma_r <= pwdata[dbs_pkg::UDMA_B];
		end else if (state_r == dbs_pkg::SEQ_DONE) begin
			go_r <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Data path
	// ------------------------------------------------------------
	wire logic [15:0] to_bus;
	wire logic [15:0] from_bus;
	wire logic        strobing;

	// The strobe window is the time spent in the strobe state.
	assign strobing = state_r == dbs_pkg::SEQ_STROBE;

	// RAM data toward the bus.
	dbs_swap u_swap_out (
		.din     (ram_rdata),
		.swap_en (swap_on),
		.wide    (bus_wide),
		.dout    (to_bus)
	); // R1 R2 R15

	// Bus data toward the RAM.
	dbs_swap u_swap_in (
		.din     (dma_data_in),
		.swap_en (swap_on),
		.wide    (bus_wide),
		.dout    (from_bus)
	); // R1 R2 R15

	// Data registers follow the strobe.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dma_data_out <= 16'h0000;
			ram_wdata    <= 16'h0000;
		end else if (strobing) begin
			if (dir_r)
				dma_data_out <= to_bus;
			else
				ram_wdata <= from_bus;
		end
	end

	// The bus is driven only during an outbound strobe.
	assign dma_data_oe = strobing & dir_r;

	// ------------------------------------------------------------
	// Pin polarity
	// ------------------------------------------------------------
	// In slave mode, request stands from the software start until the strobe begins, and again for the done cycle.
	dbs_pol u_req (
		.active_high (pin_mode_r[dbs_pkg::REQ_POL_B]),
		.asserted    (go_r & generic_slave_dma & ~strobing),
		.pin_level   (request_pin)
	); // R8

	// Write strobe marks an outbound strobe in master mode.
	dbs_pol u_wr (
		.active_high (pin_mode_r[dbs_pkg::WR_POL_B]),
		.asserted    (strobing & dir_r & master_dma),
		.pin_level   (write_strobe_pin)
	); // R9

	// Read strobe marks an inbound strobe in master mode.
	dbs_pol u_rd (
		.active_high (pin_mode_r[dbs_pkg::RD_POL_B]),
		.asserted    (strobing & ~dir_r & master_dma),
		.pin_level   (read_strobe_pin)
	); // R10

endmodule

// ---- tb/dbs_checker.sv ----
`timescale 1ns/1ps

// ------------------------------------------------------------
// Register port and DMA pin watcher.
// ------------------------------------------------------------
module dbs_checker (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pslverr,
	input wire logic        dma_data_oe,
	input wire logic        request_pin,
	input wire logic        write_strobe_pin,
	input wire logic        read_strobe_pin,
	input wire logic        master_dma,
	input wire logic        generic_slave_dma,
	input wire logic        bus_wide
);
	logic [7:0]      pm_r, sl_r, cf_r;
	logic            ul_r, dir_r;
	logic [6:0]      cnt_r;
	wire logic       wr = psel & penable & pwrite;
	wire logic       rd = psel & penable & !pwrite;
	wire logic       act = master_dma &
		(write_strobe_pin == pm_r[1] | read_strobe_pin == pm_r[0]);
	wire logic [5:0] n1 = {1'b0, sl_r[4:0]} + 6'h01;
	wire logic [1:0] tc = cf_r[2:1];
	wire logic [6:0] len = tc == 2'h0 ? 7'h10 : tc == 2'h1 ? 7'h0A :
		(tc == 2'h3 && ul_r) ? {n1, 1'b0} : 7'h06;
	wire logic       map = paddr inside {8'h3C, 8'h60, 8'h64, 8'h68, 8'h6C};

	// Shadow registers follow committed writes; the counter times strobes.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pm_r  <= 8'h04;
			sl_r  <= 8'h1F;
			cf_r  <= 8'h01;
			ul_r  <= 1'b0;
			dir_r <= 1'b0;
			cnt_r <= 7'h00;
		end else begin
			if (wr && paddr == 8'h3C) pm_r <= pwdata[7:0];
			if (wr && paddr == 8'h60) sl_r <= pwdata[7:0];
			if (wr && paddr == 8'h64) cf_r <= pwdata[7:0];
			if (wr && paddr == 8'h6C && pwdata[0]) ul_r <= pwdata[2];
			if (wr && paddr == 8'h6C && pwdata[0]) dir_r <= pwdata[1];
			cnt_r <= act ? cnt_r + 7'h01 : 7'h00;
		end
	end

	default clocking dcb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	chk_mode_level: assert property (master_dma == pm_r[4] &&
		generic_slave_dma == !pm_r[4]) else $error("mode pins wrong");
	chk_bus_width: assert property (bus_wide == cf_r[0])
		else $error("bus width pin wrong");
	chk_strobe_len: assert property ($fell(act) |-> cnt_r == len)
		else $error("strobe length wrong");
	chk_oe_master: assert property (dma_data_oe && master_dma |->
		act && dir_r) else $error("bus driven outside a write strobe");
	chk_slave_idle: assert property (generic_slave_dma |->
		write_strobe_pin != pm_r[1] && read_strobe_pin != pm_r[0])
		else $error("strobe active in slave mode");
	chk_master_req: assert property (master_dma |->
		request_pin != pm_r[2]) else $error("request active in master mode");
	chk_unmapped: assert property (psel && penable |-> pslverr == !map)
		else $error("slave error flag wrong");
	chk_mode_read: assert property (rd && paddr == 8'h3C |->
		prdata == {24'h0, pm_r}) else $error("mode register read wrong");
endmodule

bind dbs_top dbs_checker chk (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pslverr(pslverr), .dma_data_oe(dma_data_oe),
	.request_pin(request_pin), .write_strobe_pin(write_strobe_pin),
	.read_strobe_pin(read_strobe_pin), .master_dma(master_dma),
	.generic_slave_dma(generic_slave_dma), .bus_wide(bus_wide));

// ---- tb/dbs_far.sv ----
`timescale 1ns/1ps

// ------------------------------------------------------------
// Far-side model: acknowledge, end of transfer and bus data.
// ------------------------------------------------------------
module dbs_far (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        request_pin,
	input  wire logic        read_strobe_pin,
	input  wire logic        req_pol,
	input  wire logic        acknowledge_polarity,
	input  wire logic        rd_pol,
	input  wire logic        transfer_end_polarity,
	input  wire logic        end_now,
	input  wire logic        slow,
	input  wire logic [15:0] rd_word,
	output wire logic        acknowledge_pin,
	output wire logic        transfer_end_input,
	output wire logic [15:0] dma_data_in
);
	logic seen_r, ack_r;

	// Acknowledge follows a request one clock later, two when slow.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			seen_r <= 1'b0;
			ack_r  <= 1'b0;
		end else begin
			seen_r <= request_pin == req_pol;
			ack_r  <= slow ? seen_r : request_pin == req_pol;
		end
	end

	// Pins at the levels chosen for the run; data is inverted unstrobed.
	assign acknowledge_pin    = ack_r ? acknowledge_polarity : !acknowledge_polarity;
	assign transfer_end_input = end_now ? transfer_end_polarity : !transfer_end_polarity;
	assign dma_data_in = read_strobe_pin == rd_pol ? rd_word : ~rd_word;
endmodule

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps

// ------------------------------------------------------------
// Self-checking bench for the DMA bus signal configuration.
// ------------------------------------------------------------
module tb_top;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, r, v;
	logic [15:0] ram_rdata, dma_data_out, dma_data_in, ram_wdata, rd_word;
	logic        dma_data_oe, request_pin, acknowledge_pin, end_in;
	logic        write_strobe_pin, read_strobe_pin, master_dma;
	logic        generic_slave_dma, bus_wide, err, sw, wd;
	logic        req_pol, acknowledge_polarity, rd_pol, transfer_end_polarity, end_now, slow;
	int          fails, n_checks, seed, k;

	dbs_top dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.ram_rdata(ram_rdata), .dma_data_out(dma_data_out),
		.dma_data_oe(dma_data_oe), .dma_data_in(dma_data_in),
		.ram_wdata(ram_wdata), .request_pin(request_pin),
		.acknowledge_pin(acknowledge_pin), .transfer_end_input(end_in),
		.write_strobe_pin(write_strobe_pin),
		.read_strobe_pin(read_strobe_pin), .master_dma(master_dma),
		.generic_slave_dma(generic_slave_dma), .bus_wide(bus_wide));

	dbs_far far (.pclk(pclk), .presetn(presetn), .request_pin(request_pin),
		.read_strobe_pin(read_strobe_pin), .req_pol(req_pol),
		.acknowledge_polarity(acknowledge_polarity), .rd_pol(rd_pol), .transfer_end_polarity(transfer_end_polarity),
		.end_now(end_now), .slow(slow), .rd_word(rd_word),
		.acknowledge_pin(acknowledge_pin), .transfer_end_input(end_in),
		.dma_data_in(dma_data_in));

	always #12.5 pclk = ~pclk;

	// Expected bus word: halves exchanged by width when swapping.
	function automatic logic [15:0] xp(input logic [15:0] d,
		input logic s, input logic w);
		if (!s) return d;
		return w ? {d[7:0], d[15:8]} : {d[15:8], d[3:0], d[7:4]};
	endfunction

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		n_checks++;
		if (s !== e) begin
			fails++;
			$display("CHECK FAILED at %0t: saw %h want %h", $time, s, e);
		end
	endtask

	task automatic wrap_up;
		if (fails == 0 && n_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic lim;
		if (k >= 200) begin
			fails++;
			$display("CHECK FAILED at %0t: wait ran out", $time);
			wrap_up();
		end
	endtask

	// One APB transfer; read data and error flag are taken at pready.
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 200);
		lim();
		r   = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	// Polls one status bit until it reaches the given level.
	task automatic poll_st(input int b, input logic lv);
		int j;
		j = 0;
		do begin
			apb(1'b0, 8'h68, 32'h0);
			j++;
		end while (r[b] !== lv && j < 200);
		k = j;
		lim();
	endtask

	// Runs one transfer and checks the data moved in its direction.
	task automatic xfer(input logic o);
		logic [15:0] m;
		m = wd ? 16'hFFFF : 16'h00FF;
		k = 0;
		while (o && dma_data_oe !== 1'b1 && k < 200) begin
			@(posedge pclk);
			k++;
		end
		lim();
		@(posedge pclk);
		if (o) chk(dma_data_out & m, xp(ram_rdata, sw, wd) & m);
		poll_st(0, 1'b0);
		if (!o) chk(ram_wdata & m, xp(rd_word, sw, wd) & m);
	endtask

	initial begin
		{pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		{acknowledge_polarity, rd_pol, transfer_end_polarity, end_now, slow, fails, n_checks} = '0;
		req_pol = 1'b1;
		ram_rdata = 16'h0;
		rd_word = 16'hA55A;
		seed = 32'hD950;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, 8'h3C, 32'h0);
		chk(r, 32'h04);
		apb(1'b0, 8'h60, 32'h0);
		chk(r, 32'h1F);
		apb(1'b0, 8'h64, 32'h0);
		chk(r, 32'h01);
		chk(request_pin, 1'b0);
		apb(1'b0, 8'h10, 32'h0);
		chk(err, 1'b1);
		apb(1'b0, 8'h68, 32'h0);
		chk(r, 32'h6);
		for (int i = 0; i < 4; i++) begin
			v = $random(seed);
			apb(1'b1, 8'h60, v >> 8);
			apb(1'b0, 8'h60, 32'h0);
			chk(r, {24'h0, v[15:8]});
			apb(1'b1, 8'h3C, {24'h0, 1'b0, v[6:0]});
		end
		// Master transfers over every timing code, with and without ultra.
		for (int t = 0; t < 8; t++) begin
			v  = $random(seed);
			sw = v[8] & !t[2];
			wd = v[11];
			apb(1'b1, 8'h60, {27'h0, v[4:0]});
			apb(1'b1, 8'h3C, {24'h0, 1'b0, v[8], 4'h5, v[9], v[10]});
			apb(1'b1, 8'h64, {29'h0, t[1:0], wd});
			rd_pol    <= v[10];
			ram_rdata <= v[31:16];
			apb(1'b1, 8'h6C, {29'h0, t[2], t[0], 1'b1});
			xfer(t[0]);
		end
		// Slave transfers with random request and acknowledge levels.
		for (int i = 0; i < 2; i++) begin
			v  = $random(seed);
			sw = 1'b1;
			wd = 1'b1;
			req_pol <= v[0];
			acknowledge_polarity <= v[1];
			slow    <= i[0];
			apb(1'b1, 8'h64, 32'h1);
			apb(1'b1, 8'h3C, {24'h0, 4'h4, v[1], v[0], 2'h0});
			// Let the synchronised acknowledge settle at its new polarity.
			repeat (8) @(posedge pclk);
			chk(request_pin, !v[0]);
			apb(1'b1, 8'h6C, 32'h3);
			@(posedge pclk);
			chk(request_pin, v[0]);
			xfer(1'b1);
			chk(request_pin, !v[0]);
		end
		// End-of-transfer input seen at both polarities.
		transfer_end_polarity <= 1'b1;
		end_now <= 1'b1;
		apb(1'b1, 8'h3C, 32'h20);
		poll_st(2, 1'b1);
		chk(r[3:2], 2'h3);
		end_now <= 1'b0;
		poll_st(2, 1'b0);
		apb(1'b1, 8'h68, 32'h0);
		apb(1'b0, 8'h68, 32'h0);
		chk(r[3], 1'b0);
		apb(1'b1, 8'h3C, 32'h00);
		poll_st(3, 1'b1);
		chk(r[3:2], 2'h2);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, 8'h3C, 32'h0);
		chk(r, 32'h04);
		wrap_up();
	end
endmodule
